// [hdl/can_acceptance_filter.v]
// Purpose: shared identifier acceptance filter with lookup table and registers
// Assumes: controllers present a received identifier with a valid/ready pair
// Notes: linear search, one table word every two cycles
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "can_af_defines.vh"

// Behaviour
// - 512 by 32 lookup memory holds 1024 standard or 512 extended identifiers.
// - off without bypass: search halted, free cpu access, every frame dropped.
// - bypass: search halted, free cpu access, every frame kept.
// - off and bypass clear: hardware filtering, cpu reads memory, toggles disable bits of standard words.
// - auto_store_enable set while running: auto-store table searched for standard ids.
// - memory takes full words only; writes in off or bypass, reads always.
// - section registers written only in off or bypass, read always.
// - four 12-bit section starts and a 12-bit table_end register.
// - auto-store empty at zero start; later section empty when bounds equal.
// - running-mode write to a standard word changes only its disable bits.
// - extended identifiers never search the auto-store table.
// - tables lie back to back; equal start and next boundary means empty.
// - controller signals a full identifier; filter takes number, size, identifier.
// - auto-store table first for standard ids when enabled, then individual table.
// - individual exact match keeps the frame and returns a match index.
// - individual miss leads to range search; range hit keeps with index.
// - no match in individual or range table drops the frame.
module can_acceptance_filter #(
	parameter RAM_AW = 9
) (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// register bus
	input wire [`AF_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// identifier request from a controller
	input wire rx_id_valid,
	output wire rx_id_ready,
	input wire [2:0] rx_ctrl_num,
	input wire rx_id_ext,
	input wire [28:0] rx_id,
	// answer to the controller
	output reg result_valid,
	output reg result_keep,
	output reg result_auto_store,
	output reg [2:0] result_ctrl,
	output reg [9:0] match_index
);

	localparam S_IDLE = 2'h0;
	localparam S_AUTO = 2'h1;
	localparam S_IND = 2'h2;
	localparam S_RNG = 2'h3;

	// ----------------------------------------------------------------
	// configuration state
	// ----------------------------------------------------------------
	reg filter_off_bit;
	reg filter_bypass_bit;
	reg auto_store_enable;
	reg [11:0] std_individual_start;
	reg [11:0] std_group_start;
	reg [11:0] ext_individual_start;
	reg [11:0] ext_group_start;
	reg [11:0] table_end;

	// search state
	reg [1:0] state;
	reg [9:0] ptr;
	reg [9:0] lim;
	reg phase;
	reg pair_half;
	reg [31:0] lo_word;
	reg [2:0] key_ctrl;
	reg [28:0] key_id;
	reg key_ext;

	// bus access sequencer
	reg [1:0] cpu_cnt;

	wire [31:0] ram_q;
	wire mode_off;
	wire mode_bypass;
	wire mode_run;
	wire cpu_req;
	wire cpu_is_ram;
	wire [RAM_AW-1:0] cpu_word;
	wire [2:0] reg_idx;
	wire full_word;
	wire in_std_area;
	wire ram_we;
	wire [31:0] ram_mask;
	wire [RAM_AW-1:0] ram_addr;
	wire sect_wr;
	wire [9:0] w_sis;
	wire [9:0] w_sgs;
	wire [9:0] w_eis;
	wire [9:0] w_egs;
	wire [9:0] w_end;
	wire [13:0] k14;
	wire [31:0] k32;
	wire hit_hi;
	wire hit_lo;
	wire std_rng_hit;
	wire ext_rng_hit;
	wire ext_ind_hit;
	wire tbl_done;
	reg [31:0] reg_rdata;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign mode_off = filter_off_bit & ~filter_bypass_bit;
	assign mode_bypass = filter_bypass_bit;
	assign mode_run = ~filter_off_bit & ~filter_bypass_bit;

	// section boundaries as word indices
	assign w_sis = std_individual_start[11:2];
	assign w_sgs = std_group_start[11:2];
	assign w_eis = ext_individual_start[11:2];
	assign w_egs = ext_group_start[11:2];
	assign w_end = table_end[11:2];

	// ----------------------------------------------------------------
	// bus slave decode
	// ----------------------------------------------------------------
	assign cpu_req = avs_read | avs_write;
	assign cpu_is_ram = ~avs_address[`AF_REG_SEL_BIT];
	assign cpu_word = avs_address[RAM_AW+1:2];
	assign reg_idx = avs_address[4:2];
	assign full_word = (avs_byteenable == `AF_BE_FULL);
	assign avs_waitrequest = ~(cpu_cnt == 2'h3);
	assign in_std_area = ({1'b0, cpu_word} < w_eis);

	// memory write gating: full words in off or bypass, disable bits of standard-area words while running
	assign ram_we = (cpu_cnt == 2'h1) & avs_write & cpu_is_ram & full_word
		& (~mode_run | in_std_area);
	assign ram_mask = mode_run ? `AF_DIS_MASK : `AF_FULL_MASK;
	// only a memory access takes the address from the bus, and it starts only with the search idle
	assign ram_addr = ((cpu_cnt != 2'h0) & cpu_is_ram) ? cpu_word : ptr[RAM_AW-1:0];
	assign sect_wr = (cpu_cnt == 2'h1) & avs_write & ~cpu_is_ram & full_word
		& ~mode_run;

	// request accepted only when idle and no bus request or bus cycle is under way
	assign rx_id_ready = (state == S_IDLE) & (cpu_cnt == 2'h0) & ~cpu_req;

	// lookup memory
	can_lut_ram #(
		.AW(RAM_AW),
		.DW(32)
	) u_lut_ram (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.addr(ram_addr),
		.wr_en(ram_we),
		.wr_mask(ram_mask),
		.wr_data(avs_writedata),
		.rd_data(ram_q)
	);

	// ----------------------------------------------------------------
	// entry comparison
	// ----------------------------------------------------------------
	assign k14 = {key_ctrl, key_id[10:0]};
	assign k32 = {key_ctrl, key_id};
	// standard entries, upper halfword first
	assign hit_hi = ~ram_q[16+`AF_STD_DIS] & (ram_q[31:29] == key_ctrl)
		& (ram_q[26:16] == key_id[10:0]);
	assign hit_lo = ~ram_q[`AF_STD_DIS] & (ram_q[`AF_STD_CTRL] == key_ctrl)
		& (ram_q[`AF_STD_ID] == key_id[10:0]);
	// standard range: lower bound upper half, upper bound lower half
	assign std_rng_hit = ~ram_q[16+`AF_STD_DIS] & ~ram_q[`AF_STD_DIS]
		& (k14 >= {ram_q[31:29], ram_q[26:16]})
		& (k14 <= {ram_q[`AF_STD_CTRL], ram_q[`AF_STD_ID]});
	assign ext_ind_hit = (ram_q == k32);
	assign ext_rng_hit = (k32 >= lo_word) & (k32 <= ram_q);
	assign tbl_done = (ptr >= lim);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	always @* begin
		case (reg_idx)
			`AF_REG_MODE: reg_rdata = {29'h0, auto_store_enable, filter_bypass_bit,
				filter_off_bit};
			`AF_REG_STD_IND: reg_rdata = {20'h0, std_individual_start};
			`AF_REG_STD_GRP: reg_rdata = {20'h0, std_group_start};
			`AF_REG_EXT_IND: reg_rdata = {20'h0, ext_individual_start};
			`AF_REG_EXT_GRP: reg_rdata = {20'h0, ext_group_start};
			`AF_REG_TABLE_END: reg_rdata = {20'h0, table_end};
			`AF_REG_STATUS: reg_rdata = {20'h0, match_index, result_keep,
				(state != S_IDLE)};
			default: reg_rdata = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// bus sequencer: take, act, capture, answer
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_cnt <= 2'h0;
			avs_readdata <= 32'h0;
		end else begin
			case (cpu_cnt)
				2'h0: begin
					// memory waits for an idle search
					if (cpu_req & (~cpu_is_ram | (state == S_IDLE))) begin
						cpu_cnt <= 2'h1;
					end
				end
				2'h1: cpu_cnt <= 2'h2;
				2'h2: begin
					avs_readdata <= cpu_is_ram ? ram_q : reg_rdata;
					cpu_cnt <= 2'h3;
				end
				default: cpu_cnt <= 2'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			filter_off_bit <= `AF_OFF_RESET;
			filter_bypass_bit <= `AF_BYPASS_RESET;
			auto_store_enable <= `AF_AUTO_RESET;
			std_individual_start <= `AF_SECT_RESET;
			std_group_start <= `AF_SECT_RESET;
			ext_individual_start <= `AF_SECT_RESET;
			ext_group_start <= `AF_SECT_RESET;
			table_end <= `AF_SECT_RESET;
		end else begin
			// mode register writable in every mode
			if ((cpu_cnt == 2'h1) & avs_write & ~cpu_is_ram & full_word
				& (reg_idx == `AF_REG_MODE)) begin
				filter_off_bit <= avs_writedata[`AF_MODE_OFF];
				filter_bypass_bit <= avs_writedata[`AF_MODE_BYPASS];
				auto_store_enable <= avs_writedata[`AF_MODE_AUTO];
			end
			// section boundaries, low two bits always zero
			if (sect_wr) begin
				case (reg_idx)
					`AF_REG_STD_IND: std_individual_start <= avs_writedata[11:0] & `AF_SECT_MASK;
					`AF_REG_STD_GRP: std_group_start <= avs_writedata[11:0] & `AF_SECT_MASK;
					`AF_REG_EXT_IND: ext_individual_start <= avs_writedata[11:0] & `AF_SECT_MASK;
					`AF_REG_EXT_GRP: ext_group_start <= avs_writedata[11:0] & `AF_SECT_MASK;
					`AF_REG_TABLE_END: table_end <= avs_writedata[11:0] & `AF_SECT_MASK;
					default: table_end <= table_end;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// search engine
	// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= S_IDLE;
			ptr <= 10'h0;
			lim <= 10'h0;
			phase <= 1'b0;
			pair_half <= 1'b0;
			lo_word <= 32'h0;
			key_ctrl <= 3'h0;
			key_id <= 29'h0;
			key_ext <= 1'b0;
			result_valid <= 1'b0;
			result_keep <= 1'b0;
			result_auto_store <= 1'b0;
			result_ctrl <= 3'h0;
			match_index <= 10'h0;
		end else begin
			result_valid <= 1'b0;
			if (mode_off | mode_bypass) begin
				// off or bypass hold the engine reset and halted
				state <= S_IDLE;
				phase <= 1'b0;
				pair_half <= 1'b0;
				if (rx_id_valid & rx_id_ready) begin
					result_valid <= 1'b1;
					result_keep <= mode_bypass;
					result_auto_store <= 1'b0;
					result_ctrl <= rx_ctrl_num;
					match_index <= 10'h0;
				end
			end else begin
				case (state)
					S_IDLE: begin
						if (rx_id_valid & rx_id_ready) begin
							key_ctrl <= rx_ctrl_num;
							key_id <= rx_id;
							key_ext <= rx_id_ext;
							phase <= 1'b0;
							pair_half <= 1'b0;
							if (~rx_id_ext & auto_store_enable & (w_sis != 10'h0)) begin
								state <= S_AUTO;
								ptr <= 10'h0;
								lim <= w_sis;
							end else if (~rx_id_ext) begin
								state <= S_IND;
								ptr <= w_sis;
								lim <= w_sgs;
							end else begin
								state <= S_IND;
								ptr <= w_eis;
								lim <= w_egs;
							end
						end
					end
					S_AUTO, S_IND: begin
						if (tbl_done) begin
							// next table of the same size
							phase <= 1'b0;
							if (state == S_AUTO) begin
								state <= S_IND;
								ptr <= w_sis;
								lim <= w_sgs;
							end else begin
								state <= S_RNG;
								ptr <= key_ext ? w_egs : w_sgs;
								lim <= key_ext ? w_end : w_eis;
							end
						end else if (~phase) begin
							phase <= 1'b1;
						end else if (key_ext ? ext_ind_hit : (hit_hi | hit_lo)) begin
							state <= S_IDLE;
							result_valid <= 1'b1;
							result_keep <= 1'b1;
							result_auto_store <= (state == S_AUTO);
							result_ctrl <= key_ctrl;
							match_index <= key_ext ? ptr : {ptr[8:0], ~hit_hi};
						end else begin
							ptr <= ptr + 10'h1;
							phase <= 1'b0;
						end
					end
					S_RNG: begin
						if (tbl_done) begin
							state <= S_IDLE;
							result_valid <= 1'b1;
							result_keep <= 1'b0;
							result_auto_store <= 1'b0;
							result_ctrl <= key_ctrl;
							match_index <= 10'h0;
						end else if (~phase) begin
							phase <= 1'b1;
						end else if (key_ext & ~pair_half) begin
							// first word of an extended pair is the lower bound
							lo_word <= ram_q;
							pair_half <= 1'b1;
							ptr <= ptr + 10'h1;
							phase <= 1'b0;
						end else if (key_ext ? ext_rng_hit : std_rng_hit) begin
							state <= S_IDLE;
							result_valid <= 1'b1;
							result_keep <= 1'b1;
							result_auto_store <= 1'b0;
							result_ctrl <= key_ctrl;
							match_index <= ptr;
						end else begin
							pair_half <= 1'b0;
							ptr <= ptr + 10'h1;
							phase <= 1'b0;
						end
					end
					default: state <= S_IDLE;
				endcase
			end
		end
	end

endmodule

// [hdl/can_af_defines.vh]
// Purpose: constants shared by the identifier acceptance filter files
// Assumes: byte addresses on the register bus, 32-bit words
// Notes: definitions only
`ifndef CAN_AF_DEFINES_VH
`define CAN_AF_DEFINES_VH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define AF_ADDR_W 12
`define AF_REG_SEL_BIT 11
`define AF_REG_MODE 3'h0
`define AF_REG_STD_IND 3'h1
`define AF_REG_STD_GRP 3'h2
`define AF_REG_EXT_IND 3'h3
`define AF_REG_EXT_GRP 3'h4
`define AF_REG_TABLE_END 3'h5
`define AF_REG_STATUS 3'h6

// ----------------------------------------------------------------
// mode register fields and reset values
// ----------------------------------------------------------------
`define AF_MODE_OFF 0
`define AF_MODE_BYPASS 1
`define AF_MODE_AUTO 2
`define AF_OFF_RESET 1'h1
`define AF_BYPASS_RESET 1'h0
`define AF_AUTO_RESET 1'h0
`define AF_SECT_RESET 12'h000
`define AF_SECT_MASK 12'hFFC

// ----------------------------------------------------------------
// table entry layout
// ----------------------------------------------------------------
`define AF_STD_CTRL 15:13
`define AF_STD_DIS 12
`define AF_STD_ID 10:0
`define AF_DIS_MASK 32'h10001000
`define AF_FULL_MASK 32'hFFFFFFFF
`define AF_BE_FULL 4'hF

`endif

// [hdl/can_lut_ram.v]
// Purpose: single port lookup table memory with bit write mask
// Assumes: one clock, read data one cycle after the address
// Notes: a masked write keeps the unmasked bits of the stored word
`timescale 1ns/100ps

module can_lut_ram #(
	parameter AW = 9,
	parameter DW = 32
) (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// access port
	input wire [AW-1:0] addr,
	input wire wr_en,
	input wire [DW-1:0] wr_mask,
	input wire [DW-1:0] wr_data,
	output reg [DW-1:0] rd_data
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// masked write, no reset on the array
	always @(posedge sys_clk) begin
		if (wr_en) begin
			mem[addr] <= (mem[addr] & ~wr_mask) | (wr_data & wr_mask);
		end
	end

	// registered read port
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= {DW{1'b0}};
		end else begin
			rd_data <= mem[addr];
		end
	end

endmodule

// [sim/can_af_chk.sv]
// Purpose: port checker for the identifier acceptance filter
// Assumes: mode register at byte 0x800, full-word writes only
// Notes: bound to the filter top after the module
`timescale 1ns/100ps
module can_af_chk (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// register bus
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// identifier port
	input wire rx_id_valid,
	input wire rx_id_ready,
	input wire [2:0] rx_ctrl_num,
	input wire result_valid,
	input wire result_keep,
	input wire [2:0] result_ctrl
);
	reg [1:0] mode;
	reg [2:0] took_ctrl;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// shadow of off and bypass bits, controller of the request taken
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode <= 2'h1;
			took_ctrl <= 3'h0;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address == 12'h800 && avs_byteenable == 4'hF)
				mode <= avs_writedata[1:0];
			if (rx_id_valid && rx_id_ready)
				took_ctrl <= rx_ctrl_num;
		end
	end
	property p_wait_pulse;
		$fell(avs_waitrequest) |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
	property p_wait_cause;
		!avs_waitrequest |-> (avs_read || avs_write);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
	property p_reg_lat;
		$rose(avs_read) && avs_address[11] |-> avs_waitrequest[*3] ##1 !avs_waitrequest;
	endproperty
	a_reg_lat: assert property (p_reg_lat) else $error("register read latency");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address == 12'h81C |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped register not zero");
	property p_result_pulse;
		result_valid |=> !result_valid;
	endproperty
	a_result_pulse: assert property (p_result_pulse) else $error("result pulse too long");
	property p_echo;
		result_valid |-> result_ctrl == took_ctrl;
	endproperty
	a_echo: assert property (p_echo) else $error("result for wrong controller");
	property p_off;
		rx_id_valid && rx_id_ready && mode == 2'h1 |=> result_valid && !result_keep;
	endproperty
	a_off: assert property (p_off) else $error("off mode kept a frame");
	property p_bypass;
		rx_id_valid && rx_id_ready && mode[1] |=> result_valid && result_keep;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass mode dropped a frame");
	property p_keep_hold;
		!result_valid |-> $stable(result_keep);
	endproperty
	a_keep_hold: assert property (p_keep_hold) else $error("keep changed between results");
endmodule

bind can_acceptance_filter can_af_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rx_id_valid(rx_id_valid), .rx_id_ready(rx_id_ready), .rx_ctrl_num(rx_ctrl_num),
	.result_valid(result_valid), .result_keep(result_keep), .result_ctrl(result_ctrl));

// [sim/can_ctrl_model.sv]
// Purpose: receive side of a controller that asks the filter about identifiers
// Assumes: one request at a time, held until taken
// Notes: released lines show the inverse of the last value
`timescale 1ns/100ps
module can_ctrl_model (
	// clock
	input wire sys_clk,
	// identifier request
	output reg rx_id_valid,
	input wire rx_id_ready,
	output reg [2:0] rx_ctrl_num,
	output reg rx_id_ext,
	output reg [28:0] rx_id,
	// answer
	input wire result_valid,
	input wire result_keep,
	input wire result_auto_store,
	input wire [9:0] match_index
);
	initial begin
		rx_id_valid = 1'b0;
		rx_ctrl_num = 3'h0;
		rx_id_ext = 1'b0;
		rx_id = 29'h0;
	end
	// signal a full identifier, wait for the answer
	task send(input [2:0] c, input e, input [28:0] id, input integer gap,
		output got, output k, output a, output [9:0] ix);
		integer n;
		begin
			got = 1'b0;
			k = 1'b0;
			a = 1'b0;
			ix = 10'h000;
			repeat (gap) @(posedge sys_clk);
			@(posedge sys_clk);
			rx_id_valid <= 1'b1;
			rx_ctrl_num <= c;
			rx_id_ext <= e;
			rx_id <= id;
			n = 0;
			@(negedge sys_clk);
			while (!rx_id_ready && n < 300) begin
				@(negedge sys_clk);
				n = n + 1;
			end
			@(posedge sys_clk);
			rx_id_valid <= 1'b0;
			rx_ctrl_num <= ~c;
			rx_id_ext <= ~e;
			rx_id <= ~id;
			n = 0;
			while (!got && n < 300) begin
				@(negedge sys_clk);
				n = n + 1;
				if (result_valid === 1'b1) begin
					got = 1'b1;
					k = result_keep;
					a = result_auto_store;
					ix = match_index;
				end
			end
		end
	endtask
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the acceptance filter
// Assumes: 20 MHz clock, controller model on the identifier port
// Notes: tables built in off or bypass mode, searched in running mode
`timescale 1ns/100ps
module testbench;
	reg sys_clk, reset_n, avs_read, avs_write;
	reg [11:0] avs_address;
	reg [31:0] avs_writedata, rd;
	reg [3:0] avs_byteenable;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, rx_id_valid, rx_id_ready, rx_id_ext;
	wire result_valid, result_keep, result_auto_store;
	wire [2:0] rx_ctrl_num, result_ctrl;
	wire [28:0] rx_id;
	wire [9:0] match_index;
	reg g, kk, aa;
	reg [9:0] ii;
	integer fails, tests_run, cycles, slow;
	can_acceptance_filter dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rx_id_valid(rx_id_valid), .rx_id_ready(rx_id_ready), .rx_ctrl_num(rx_ctrl_num),
		.rx_id_ext(rx_id_ext), .rx_id(rx_id), .result_valid(result_valid),
		.result_keep(result_keep), .result_auto_store(result_auto_store),
		.result_ctrl(result_ctrl), .match_index(match_index));
	can_ctrl_model ctrl_u (.sys_clk(sys_clk), .rx_id_valid(rx_id_valid),
		.rx_id_ready(rx_id_ready), .rx_ctrl_num(rx_ctrl_num), .rx_id_ext(rx_id_ext),
		.rx_id(rx_id), .result_valid(result_valid), .result_keep(result_keep),
		.result_auto_store(result_auto_store), .match_index(match_index));
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task end_sim;
		begin
			$display("mismatches %0d comparisons %0d", fails, tests_run);
			if (fails == 0 && tests_run > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task check(input [31:0] v, input [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (v !== e) begin
				fails = fails + 1;
				$display("wrong value at %0t: got %h expected %h", $time, v, e);
			end
		end
	endtask
	// one bus cycle, held until waitrequest is seen low
	task bus(input w, input [11:0] ad, input [31:0] d, input [3:0] be);
		integer n;
		begin
			@(posedge sys_clk);
			avs_read <= !w;
			avs_write <= w;
			avs_address <= ad;
			avs_writedata <= d;
			avs_byteenable <= be;
			n = 0;
			@(negedge sys_clk);
			while (avs_waitrequest !== 1'b0 && n < 300) begin
				@(negedge sys_clk);
				n = n + 1;
			end
			@(posedge sys_clk);
			rd = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			check(n < 300, 1);
		end
	endtask
	task wr(input [11:0] ad, input [31:0] d);
		bus(1'b1, ad, d, 4'hF);
	endtask
	task rdck(input [11:0] ad, input [31:0] e);
		begin
			bus(1'b0, ad, 32'h0, 4'hF);
			check(rd, e);
		end
	endtask
	task idck(input [2:0] c, input e, input [28:0] id, input ek, input ea, input [9:0] ei);
		begin
			ctrl_u.send(c, e, id, slow, g, kk, aa, ii);
			check({g, kk, aa, ii}, {1'b1, ek, ea, ei});
		end
	endtask
	task drop(input [2:0] c, input e, input [28:0] id);
		begin
			ctrl_u.send(c, e, id, slow, g, kk, aa, ii);
			check({g, kk}, 2'h2);
		end
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task t_reset;
		integer i;
		begin
			rdck(12'h800, 32'h1);
			for (i = 1; i < 6; i = i + 1)
				rdck(12'h800 + 4 * i, 32'h0);
			drop(3'h1, 1'b0, 29'h100);
		end
	endtask
	task t_ram;
		begin
			wr(12'h014, 32'hA5A55A5A);
			rdck(12'h014, 32'hA5A55A5A);
			bus(1'b1, 12'h014, 32'h0, 4'h3);
			rdck(12'h014, 32'hA5A55A5A);
			rdck(12'h81C, 32'h0);
		end
	endtask
	task t_tables;
		begin
			wr(12'h000, 32'h21002200);
			wr(12'h004, 32'h23002350);
			wr(12'h008, 32'h20012345);
			wr(12'h00C, 32'h20020000);
			wr(12'h010, 32'h20020FFF);
			wr(12'h808, 32'h7);
			rdck(12'h808, 32'h4);
			wr(12'h80C, 32'h8);
			wr(12'h810, 32'hC);
			wr(12'h814, 32'h14);
			wr(12'h800, 32'h2);
			idck(3'h2, 1'b1, 29'h1ABCDEF, 1'b1, 1'b0, 10'h0);
			wr(12'h800, 32'h3);
			idck(3'h1, 1'b0, 29'h7FF, 1'b1, 1'b0, 10'h0);
		end
	endtask
	task t_search;
		begin
			wr(12'h800, 32'h0);
			idck(3'h1, 1'b0, 29'h100, 1'b1, 1'b0, 10'h0);
			slow = 4;
			idck(3'h1, 1'b0, 29'h200, 1'b1, 1'b0, 10'h1);
			slow = 0;
			idck(3'h1, 1'b0, 29'h350, 1'b1, 1'b0, 10'h1);
			drop(3'h1, 1'b0, 29'h400);
			drop(3'h2, 1'b0, 29'h100);
			drop(3'h1, 1'b1, 29'h100);
			idck(3'h1, 1'b1, 29'h12345, 1'b1, 1'b0, 10'h2);
			idck(3'h1, 1'b1, 29'h20FFF, 1'b1, 1'b0, 10'h4);
			rdck(12'h818, 32'h12);
			drop(3'h1, 1'b1, 29'h21000);
		end
	endtask
	task t_locked;
		begin
			wr(12'h808, 32'h0);
			rdck(12'h808, 32'h4);
			wr(12'h004, 32'hFFFFFFFF);
			rdck(12'h004, 32'h33003350);
			drop(3'h1, 1'b0, 29'h320);
			wr(12'h004, 32'h0);
			rdck(12'h004, 32'h23002350);
			idck(3'h1, 1'b0, 29'h300, 1'b1, 1'b0, 10'h1);
			wr(12'h008, 32'h0);
			rdck(12'h008, 32'h20012345);
		end
	endtask
	task t_auto;
		begin
			wr(12'h800, 32'h2);
			wr(12'h804, 32'h4);
			wr(12'h800, 32'h4);
			idck(3'h1, 1'b0, 29'h200, 1'b1, 1'b1, 10'h1);
			idck(3'h1, 1'b0, 29'h320, 1'b1, 1'b0, 10'h1);
			idck(3'h1, 1'b1, 29'h12345, 1'b1, 1'b0, 10'h2);
			wr(12'h800, 32'h0);
			drop(3'h1, 1'b0, 29'h100);
		end
	endtask
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// cut a hang short
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 6000) begin
			fails = fails + 1;
			end_sim;
		end
	end
	// reset then the scenarios
	initial begin
		fails = 0;
		tests_run = 0;
		cycles = 0;
		slow = 0;
		reset_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 12'h000;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset;
		t_ram;
		t_tables;
		t_search;
		t_locked;
		t_auto;
		end_sim;
	end
endmodule
